// ==== design/slc_consts.vh ====
// Purpose: constants for the serial-bus link control bits
// Assumes: included by bare name from every design file
// Notes: bit numbers count from the lsb of the register word
//
// Notes on behaviour
// - id valid: accept packets for own node
// - id invalid: accept broadcast async packets only
// - self-id capture groups self-ids into fifo
// - self-id pair is quadlet then its inverse
// - status code 1h good, dh bad
// - capture keeps first quadlet of phy packets
// - force busy: busy ack to nonbroadcast async
// - otherwise busy ack only when fifo full
// - receive all plus iso enable: every channel
// - cycle-start capture stores cycle-start packets
// - async tx disabled: no arbitration, no send
// - bus reset clears async transmit enable
// - async rx disabled; bus reset clears it
// - iso tx disabled: no arbitration, no send
// - iso rx disabled: no iso packets taken
// - ack complete selected: good write gets 0001
// - ack complete off: good write gets 0010
// - transmitter reset bit pulses, self-clears
// - receiver reset bit pulses, self-clears
// - broadcast node 3fh always passes the address check; async rx enable still gates it
`ifndef SLC_CONSTS_VH
`define SLC_CONSTS_VH

`define SLC_ADDR_W       8
`define SLC_OFS_NODE     8'h04
`define SLC_OFS_CTRL     8'h08

`define SLC_B_NODE_ID_VALID      0
`define SLC_B_SELFID     1
`define SLC_B_BUSY       2
`define SLC_B_RAI        3
`define SLC_B_CYST       4
`define SLC_B_ASYNC_TX_EN      5
`define SLC_B_ASYNC_RX_EN      6
`define SLC_B_ISO_TX_EN      7
`define SLC_B_ISO_RX_EN      8
`define SLC_B_ACKC       9
`define SLC_B_TRANSMITTER_SOFT_RESET      10
`define SLC_B_RECEIVER_SOFT_RESET      11

`define SLC_BUS_LSB      0
`define SLC_BUS_MSB      9
`define SLC_NODE_LSB     10
`define SLC_NODE_MSB     15
`define SLC_BUS_RST      10'h3ff
`define SLC_NODE_RST     6'h3f
`define SLC_BCAST_NODE   6'h3f
`define SLC_BCAST_BUS    10'h3ff

`define SLC_ACK_COMPLETE 4'h1
`define SLC_ACK_PENDING  4'h2
`define SLC_ACK_BUSY_X   4'h4
`define SLC_SID_GOOD     4'h1
`define SLC_SID_BAD      4'hd

`endif

// ==== design/slc_link_ctrl.v ====
// Purpose: link control register and the packet decisions it steers
// Assumes: packet, phy and fifo signals come from logic on ref_clk
// Notes: the decision for a header is ready one cycle after hdr_valid
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`include "slc_consts.vh"

module slc_link_ctrl #(
    parameter DW = 32
) (
    // clock and reset
    input  wire                   ref_clk,
    input  wire                   nrst,
    // register port
    input  wire [`SLC_ADDR_W-1:0] addr,
    input  wire [31:0]            wdata,
    input  wire                   wr,
    input  wire                   rd,
    output reg  [31:0]            rdata,
    // bus events from the phy side
    input  wire                   bus_reset,
    input  wire                   phy_id_valid,
    input  wire [5:0]             phy_id,
    // received packet header
    input  wire                   hdr_valid,
    input  wire [5:0]             hdr_node,
    input  wire [9:0]             hdr_bus,
    input  wire                   hdr_async,
    input  wire                   hdr_write_req,
    input  wire                   hdr_iso,
    input  wire                   hdr_cycle_start,
    input  wire                   hdr_chan_match,
    input  wire                   hdr_err,
    // self-id and phy packet quadlets
    input  wire                   sid_valid,
    input  wire [DW-1:0]          sid_q,
    input  wire                   sid_done,
    input  wire                   phy_q_valid,
    input  wire                   phy_q_first,
    input  wire [DW-1:0]          phy_q,
    // general receive fifo
    input  wire                   fifo_full,
    output reg                    fifo_wr,
    output reg  [DW-1:0]          fifo_data,
    // receive decisions
    output reg                    rx_accept,
    output reg                    rx_store,
    output reg                    ack_valid,
    output reg  [3:0]             ack_code,
    // transmit requests
    input  wire                   tx_async_req,
    input  wire                   tx_iso_req,
    output reg                    tx_async_go,
    output reg                    tx_iso_go,
    // soft resets
    output reg                    transmitter_soft_reset,
    output reg                    receiver_soft_reset,
    // control levels
    output reg                    node_id_valid,
    output reg                    self_id_capture_en,
    output reg                    force_busy_ack,
    output reg                    iso_receive_all,
    output reg                    cycle_start_capture_en,
    output reg                    async_tx_en,
    output reg                    async_rx_en,
    output reg                    iso_tx_en,
    output reg                    iso_rx_en,
    output reg                    ack_complete_sel
);

    // ========================================================
    // register decode
    // ========================================================
    reg  [9:0] bus_number;
    reg  [5:0] node_number;
    wire       wr_ctrl = wr && (addr == `SLC_OFS_CTRL);
    wire       wr_node = wr && (addr == `SLC_OFS_NODE);
    wire [3:0] sid_status;

    reg [31:0] next_rdata;
    always @* begin
        next_rdata = 32'h0000_0000;
        if (rd && addr == `SLC_OFS_CTRL) begin
            next_rdata[`SLC_B_NODE_ID_VALID]  = node_id_valid;
            next_rdata[`SLC_B_SELFID] = self_id_capture_en;
            next_rdata[`SLC_B_BUSY]   = force_busy_ack;
            next_rdata[`SLC_B_RAI]    = iso_receive_all;
            next_rdata[`SLC_B_CYST]   = cycle_start_capture_en;
            next_rdata[`SLC_B_ASYNC_TX_EN]  = async_tx_en;
            next_rdata[`SLC_B_ASYNC_RX_EN]  = async_rx_en;
            next_rdata[`SLC_B_ISO_TX_EN]  = iso_tx_en;
            next_rdata[`SLC_B_ISO_RX_EN]  = iso_rx_en;
            next_rdata[`SLC_B_ACKC]   = ack_complete_sel;
            next_rdata[`SLC_B_TRANSMITTER_SOFT_RESET]  = 1'b0;
            next_rdata[`SLC_B_RECEIVER_SOFT_RESET]  = 1'b0;
        end else if (rd && addr == `SLC_OFS_NODE) begin
            next_rdata[`SLC_BUS_MSB:`SLC_BUS_LSB]   = bus_number;
            next_rdata[`SLC_NODE_MSB:`SLC_NODE_LSB] = node_number;
        end
    end

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rdata <= 32'h0000_0000;
        end else begin
            rdata <= next_rdata;
        end
    end

    // ========================================================
    // control register
    // ========================================================
    // a bus reset in the same cycle as a software write wins for async_tx_en
    // and async_rx_en only; the other control bits take the written value
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            node_id_valid          <= 1'b0;
            self_id_capture_en     <= 1'b0;
            force_busy_ack         <= 1'b0;
            iso_receive_all        <= 1'b0;
            cycle_start_capture_en <= 1'b0;
            async_tx_en            <= 1'b0;
            async_rx_en            <= 1'b0;
            iso_tx_en              <= 1'b0;
            iso_rx_en              <= 1'b0;
            ack_complete_sel       <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                node_id_valid          <= wdata[`SLC_B_NODE_ID_VALID];
                self_id_capture_en     <= wdata[`SLC_B_SELFID];
                force_busy_ack         <= wdata[`SLC_B_BUSY];
                iso_receive_all        <= wdata[`SLC_B_RAI];
                cycle_start_capture_en <= wdata[`SLC_B_CYST];
                async_tx_en            <= wdata[`SLC_B_ASYNC_TX_EN];
                async_rx_en            <= wdata[`SLC_B_ASYNC_RX_EN];
                iso_tx_en              <= wdata[`SLC_B_ISO_TX_EN];
                iso_rx_en              <= wdata[`SLC_B_ISO_RX_EN];
                ack_complete_sel       <= wdata[`SLC_B_ACKC];
            end
            if (bus_reset) begin
                async_tx_en <= 1'b0;
                async_rx_en <= 1'b0;
            end
        end
    end

    // ========================================================
    // self-clearing reset strobes
    // ========================================================
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            transmitter_soft_reset <= 1'b0;
            receiver_soft_reset    <= 1'b0;
        end else begin
            transmitter_soft_reset <= wr_ctrl && wdata[`SLC_B_TRANSMITTER_SOFT_RESET];
            receiver_soft_reset    <= wr_ctrl && wdata[`SLC_B_RECEIVER_SOFT_RESET];
        end
    end

    // ========================================================
    // node address register
    // ========================================================
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            bus_number  <= `SLC_BUS_RST;
            node_number <= `SLC_NODE_RST;
        end else begin
            if (wr_node) begin
                bus_number  <= wdata[`SLC_BUS_MSB:`SLC_BUS_LSB];
                node_number <= wdata[`SLC_NODE_MSB:`SLC_NODE_LSB];
            end
            // phy status transfer overrides a same-cycle write of node_number; bus_number still takes the write
            if (phy_id_valid) begin
                node_number <= phy_id;
            end
        end
    end

    // ========================================================
    // receive decision
    // ========================================================
    // broadcast always passes
    wire is_bcast  = (hdr_node == `SLC_BCAST_NODE);
    wire bus_ok    = (hdr_bus == bus_number) || (hdr_bus == `SLC_BCAST_BUS);
    wire own_match = node_id_valid && (hdr_node == node_number) && bus_ok;
    wire addr_ok   = is_bcast || own_match;
    wire async_ok  = hdr_async && async_rx_en && addr_ok;
    wire iso_ok    = hdr_iso && iso_rx_en && (iso_receive_all || hdr_chan_match);
    wire cyst_ok   = hdr_cycle_start && cycle_start_capture_en;
    wire take      = hdr_valid && !receiver_soft_reset && (async_ok || iso_ok || cyst_ok);
    // only addressed async packets are acknowledged
    wire need_ack  = hdr_valid && !receiver_soft_reset && async_ok && !is_bcast;

    reg [3:0] next_ack;
    always @* begin
        next_ack = `SLC_ACK_PENDING;
        if (force_busy_ack) begin
            next_ack = `SLC_ACK_BUSY_X;
        end else if (fifo_full) begin
            next_ack = `SLC_ACK_BUSY_X;
        end else if (hdr_write_req && ack_complete_sel) begin
            next_ack = `SLC_ACK_COMPLETE;
        end else begin
            next_ack = `SLC_ACK_PENDING;
        end
    end

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rx_accept <= 1'b0;
            rx_store  <= 1'b0;
            ack_valid <= 1'b0;
            ack_code  <= 4'h0;
        end else begin
            rx_accept <= take;
            // a busy answer means the packet is not stored
            rx_store  <= take && !(need_ack && next_ack == `SLC_ACK_BUSY_X);
            // damaged packets get no acknowledge at all
            ack_valid <= need_ack && !hdr_err;
            if (need_ack && !hdr_err) begin
                ack_code <= next_ack;
            end
        end
    end

    // ========================================================
    // self-id and phy packet capture
    // ========================================================
    wire sid_in  = self_id_capture_en && sid_valid;
    wire sid_end = self_id_capture_en && sid_done;

    slc_selfid_check #(
        .W (DW)
    ) u_sid (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .clr     (receiver_soft_reset),
        .q_valid (sid_in),
        .q       (sid_q),
        .done    (sid_end),
        .status  (sid_status)
    );

    // quadlets arrive one at a time; a full fifo drops the word,
    // the receiver logic outside is expected to have flagged it
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            fifo_wr   <= 1'b0;
            fifo_data <= {DW{1'b0}};
        end else begin
            fifo_wr <= 1'b0;
            if (receiver_soft_reset || fifo_full) begin
                fifo_wr <= 1'b0;
            end else if (sid_in) begin
                fifo_wr   <= 1'b1;
                fifo_data <= sid_q;
            end else if (sid_end) begin
                fifo_wr   <= 1'b1;
                fifo_data <= {{(DW-4){1'b0}}, sid_status};
            end else if (self_id_capture_en && phy_q_valid && phy_q_first) begin
                fifo_wr   <= 1'b1;
                fifo_data <= phy_q;
            end
        end
    end

    // ========================================================
    // transmit gating
    // ========================================================
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            tx_async_go <= 1'b0;
            tx_iso_go   <= 1'b0;
        end else begin
            tx_async_go <= tx_async_req && async_tx_en && !transmitter_soft_reset;
            tx_iso_go   <= tx_iso_req && iso_tx_en && !transmitter_soft_reset;
        end
    end

endmodule

// ==== design/slc_selfid_check.v ====
// Purpose: pairs self-id quadlets and grades the captured burst
// Assumes: q_valid and done never fall in the same cycle
// Notes: an odd quadlet left at the end grades the burst bad
`timescale 1ns/100ps
`include "slc_consts.vh"

module slc_selfid_check #(
    parameter W = 32
) (
    // clock and reset
    input  wire         ref_clk,
    input  wire         nrst,
    input  wire         clr,
    // quadlet stream
    input  wire         q_valid,
    input  wire [W-1:0] q,
    input  wire         done,
    // grade
    output wire [3:0]   status
);
    reg [W-1:0] first_q;
    reg         second;
    reg         err;

    assign status = (err || second) ? `SLC_SID_BAD : `SLC_SID_GOOD;

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            first_q <= {W{1'b0}};
            second  <= 1'b0;
            err     <= 1'b0;
        end else if (clr || done) begin
            second  <= 1'b0;
            err     <= 1'b0;
        end else if (q_valid) begin
            second  <= ~second;
            if (!second) begin
                first_q <= q;
            end else if (q != ~first_q) begin
                err <= 1'b1;
            end
        end
    end
endmodule

// ==== tb/slc_link_ctrl_tb.sv ====
// Purpose: self-checking bench for the link control block
// Assumes: register port answers one cycle after the strobe
// Notes: own bus number stays at its reset value 3ffh
`timescale 1ns/100ps
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin n_mismatch++; \
    $display("BAD %s exp %h got %h", n, e, a); end end
module slc_link_ctrl_tb;
    logic        ref_clk, nrst, wr, rd, fifo_full, tx_async_req, tx_iso_req;
    logic        phy_q_valid, phy_q_first;
    logic [7:0]  addr;
    logic [31:0] wdata, got, phy_q;
    wire  [31:0] rdata, fifo_data, sid_q;
    wire  [5:0]  phy_id, hdr_node;
    wire  [3:0]  ack_code, hdr_kind;
    wire         fifo_wr, rx_accept, rx_store, ack_valid, tx_async_go, tx_iso_go;
    wire         transmitter_soft_reset, receiver_soft_reset, node_id_valid, self_id_capture_en;
    wire         force_busy_ack, iso_receive_all, cycle_start_capture_en, async_tx_en;
    wire         async_rx_en, iso_tx_en, iso_rx_en, ack_complete_sel;
    wire         bus_reset, phy_id_valid, hdr_valid, hdr_err, sid_valid, sid_done;
    int          n_mismatch = 0, n_compared = 0;

    slc_link_ctrl i_slc_link_ctrl (.*, .hdr_bus(10'h3ff), .hdr_async(hdr_kind[3]),
        .hdr_write_req(hdr_kind[2]), .hdr_iso(hdr_kind[1]), .hdr_cycle_start(hdr_kind[0]),
        .hdr_chan_match(1'b0));
    slc_phy_model i_slc_phy_model (.*);

    // =================
    // clock and tasks
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // watchdog: a hang counts as a mismatch
    initial begin
        repeat (5000) @(posedge ref_clk);
        n_mismatch++;
        conclude;
    end
    task wreg(input [7:0] a, input [31:0] d);
        begin
            @(posedge ref_clk);
            {wr, addr, wdata} <= {1'b1, a, d};
            @(posedge ref_clk);
            wr <= 1'b0;
            #1;
        end
    endtask
    task rreg(input [7:0] a);
        begin
            @(posedge ref_clk);
            {rd, addr} <= {1'b1, a};
            @(posedge ref_clk);
            rd <= 1'b0;
            #1 got = rdata;
        end
    endtask
    // kind is {async, write, iso, cycle start}; code 0 means no ack expected
    task pk(input [5:0] n, input [3:0] k, input acc, input [3:0] code);
        begin
            i_slc_phy_model.ev(3'd2, {21'h0, 1'b0, k, n});
            #1;
            `CHK("accept", acc, rx_accept)
            // a busy answer keeps the packet out of the fifo
            `CHK("store", acc && code != 4'h4, rx_store)
            `CHK("ack valid", code != 4'h0, ack_valid)
            if (code != 4'h0) `CHK("ack code", code, ack_code)
        end
    endtask
    task conclude;
        begin
            $display("compared %0d mismatched %0d", n_compared, n_mismatch);
            if (n_mismatch == 0 && n_compared > 0) begin
                $display("ALL CHECKS OK");
            end else begin
                $display("CHECKS NOT OK");
            end
            $finish;
        end
    endtask

    // =================
    // test sequence
    initial begin
        {nrst, wr, rd, fifo_full, tx_async_req, tx_iso_req, addr, wdata} = 0;
        {phy_q_valid, phy_q_first, phy_q} = 0;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        rreg(8'h08); `CHK("ctrl reset", 32'h0, got)
        rreg(8'h04); `CHK("node reset", 32'h0000ffff, got)
        rreg(8'h0c); `CHK("unmapped", 32'h0, got)
        for (int b = 0; b < 10; b++) begin
            wreg(8'h08, 32'h1 << b);
            `CHK("levels", 10'h1 << b, {ack_complete_sel, iso_rx_en, iso_tx_en, async_rx_en,
                async_tx_en, cycle_start_capture_en, iso_receive_all, force_busy_ack,
                self_id_capture_en, node_id_valid})
        end
        wreg(8'h08, 32'hc00); `CHK("soft resets", 2'b11, {transmitter_soft_reset, receiver_soft_reset})
        @(posedge ref_clk); #1 `CHK("resets clear", 2'b00, {transmitter_soft_reset, receiver_soft_reset})
        rreg(8'h08); `CHK("reset bits", 32'h0, got)
        wreg(8'h08, 32'h0); `CHK("zero write", 2'b00, {transmitter_soft_reset, receiver_soft_reset})
        $display("test register done");
        wreg(8'h08, 32'h3ff);
        i_slc_phy_model.ev(3'd0, 32'h0);
        rreg(8'h08); `CHK("bus reset", 32'h39f, got)
        $display("test bus reset done");
        i_slc_phy_model.ev(3'd1, 32'h5);
        wreg(8'h08, 32'h040);
        pk(6'h05, 4'b1000, 1'b0, 4'h0);
        pk(6'h3f, 4'b1100, 1'b1, 4'h0);
        wreg(8'h08, 32'h241);
        pk(6'h05, 4'b1100, 1'b1, 4'h1);
        pk(6'h06, 4'b1100, 1'b0, 4'h0);
        wreg(8'h08, 32'h041);
        pk(6'h05, 4'b1100, 1'b1, 4'h2);
        @(posedge ref_clk) fifo_full <= 1'b1;
        pk(6'h05, 4'b1100, 1'b1, 4'h4);
        @(posedge ref_clk) fifo_full <= 1'b0;
        wreg(8'h08, 32'h045);
        pk(6'h05, 4'b1000, 1'b1, 4'h4);
        wreg(8'h08, 32'h001);
        pk(6'h05, 4'b1100, 1'b0, 4'h0);
        $display("test async receive done");
        wreg(8'h08, 32'h0);
        pk(6'h01, 4'b0010, 1'b0, 4'h0);
        wreg(8'h08, 32'h108);
        pk(6'h01, 4'b0010, 1'b1, 4'h0);
        wreg(8'h08, 32'h100);
        pk(6'h01, 4'b0010, 1'b0, 4'h0);
        wreg(8'h08, 32'h010);
        pk(6'h01, 4'b0001, 1'b1, 4'h0);
        $display("test iso receive done");
        @(posedge ref_clk) {tx_async_req, tx_iso_req} <= 2'b11;
        wreg(8'h08, 32'h020);
        @(posedge ref_clk); #1 `CHK("tx go", 2'b10, {tx_async_go, tx_iso_go})
        wreg(8'h08, 32'h080);
        @(posedge ref_clk); #1 `CHK("tx go", 2'b01, {tx_async_go, tx_iso_go})
        @(posedge ref_clk) {tx_async_req, tx_iso_req} <= 2'b00;
        $display("test transmit done");
        wreg(8'h08, 32'h002);
        i_slc_phy_model.ev(3'd3, 32'h12345678);
        #1 `CHK("sid word", 33'h112345678, {fifo_wr, fifo_data})
        i_slc_phy_model.ev(3'd3, 32'hedcba987);
        i_slc_phy_model.ev(3'd4, 32'h0);
        #1 `CHK("sid good", 33'h100000001, {fifo_wr, fifo_data})
        i_slc_phy_model.ev(3'd3, 32'h0000ffff);
        i_slc_phy_model.ev(3'd3, 32'h0000ffff);
        i_slc_phy_model.ev(3'd4, 32'h0);
        #1 `CHK("sid bad", 33'h10000000d, {fifo_wr, fifo_data})
        @(posedge ref_clk) {phy_q_valid, phy_q_first, phy_q} <= {2'b11, 32'h0000_e0c1};
        @(posedge ref_clk) {phy_q_valid, phy_q_first} <= 2'b10;
        #1 `CHK("phy first", 33'h10000e0c1, {fifo_wr, fifo_data})
        @(posedge ref_clk) phy_q_valid <= 1'b0;
        #1 `CHK("phy later", 1'b0, fifo_wr)
        $display("test self id done");
        conclude;
    end
endmodule
bind slc_link_ctrl slc_link_props i_slc_link_props (.*);

// ==== tb/slc_link_props.sv ====
// Purpose: port-level checks of the link control block
// Assumes: bound to slc_link_ctrl, single clock ref_clk
// Notes: control register sits at byte offset 08h
`timescale 1ns/100ps
module slc_link_props (
    // clock and reset
    input wire        ref_clk,
    input wire        nrst,
    // register port
    input wire [7:0]  addr,
    input wire [31:0] wdata,
    input wire        wr,
    input wire        rd,
    input wire [31:0] rdata,
    // events and headers
    input wire        bus_reset,
    input wire        hdr_valid,
    input wire [5:0]  hdr_node,
    input wire        hdr_async,
    input wire        hdr_iso,
    input wire        hdr_cycle_start,
    input wire        hdr_write_req,
    input wire        fifo_full,
    // decisions
    input wire        rx_accept,
    input wire        ack_valid,
    input wire [3:0]  ack_code,
    input wire        tx_async_req,
    input wire        tx_iso_req,
    input wire        tx_async_go,
    input wire        tx_iso_go,
    input wire        transmitter_soft_reset,
    input wire        receiver_soft_reset,
    // control levels
    input wire        node_id_valid,
    input wire        force_busy_ack,
    input wire        async_tx_en,
    input wire        async_rx_en,
    input wire        iso_tx_en,
    input wire        ack_complete_sel
);
    // ==========
    // properties
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    async_gate_a: assert property (tx_async_go |-> $past(tx_async_req && async_tx_en))
        else $error("async go without enable");
    iso_gate_a: assert property (tx_iso_go |-> $past(tx_iso_req && iso_tx_en))
        else $error("iso go without enable");
    bus_clear_a: assert property (bus_reset |=> !async_tx_en && !async_rx_en)
        else $error("bus reset left async enables set");
    tx_pulse_a: assert property (wr && addr == 8'h08 && wdata[10]
        |=> transmitter_soft_reset ##1 !transmitter_soft_reset) else $error("tx reset pulse");
    rx_pulse_a: assert property (wr && addr == 8'h08 && wdata[11]
        |=> receiver_soft_reset ##1 !receiver_soft_reset) else $error("rx reset pulse");
    busy_ack_a: assert property (ack_valid && $past(force_busy_ack) |-> ack_code == 4'h4)
        else $error("forced busy not busy");
    ack_sel_a: assert property (ack_valid && !$past(force_busy_ack || fifo_full)
        && $past(hdr_write_req) |-> ack_code == ($past(ack_complete_sel) ? 4'h1 : 4'h2))
        else $error("write ack code wrong");
    id_invalid_a: assert property (hdr_valid && hdr_async && !hdr_iso && !hdr_cycle_start
        && !node_id_valid && hdr_node != 6'h3f |=> !rx_accept) else $error("unicast taken");
    bcast_take_a: assert property (hdr_valid && hdr_async && hdr_node == 6'h3f
        && async_rx_en && !receiver_soft_reset |=> rx_accept && !ack_valid)
        else $error("broadcast mishandled");
    rst_read_a: assert property ($past(rd) && $past(addr) == 8'h08
        |-> rdata[11:10] == 2'b00) else $error("reset bits read nonzero");
endmodule

// ==== tb/slc_phy_model.sv ====
// Purpose: phy-side stand-in for bus events, headers and self-ids
// Assumes: ev is called from one bench process only
// Notes: released fields show their inverse, never the old value
`timescale 1ns/100ps
module slc_phy_model (
    // clock
    input  wire        ref_clk,
    // events, headers, self-id stream
    output reg         bus_reset,
    output reg         phy_id_valid,
    output reg  [5:0]  phy_id,
    output reg         hdr_valid,
    output reg  [5:0]  hdr_node,
    output reg  [3:0]  hdr_kind,
    output reg         hdr_err,
    output reg         sid_valid,
    output reg  [31:0] sid_q,
    output reg         sid_done
);
    // ======================================
    // sel 0 bus reset, 1 id, 2 header, 3 sid, 4 end
    initial begin
        {bus_reset, phy_id_valid, phy_id, hdr_valid, hdr_node, hdr_kind, hdr_err} = 0;
        {sid_valid, sid_q, sid_done} = 0;
    end
    task ev(input [2:0] sel, input [31:0] v);
        begin
            @(posedge ref_clk);
            bus_reset    <= (sel == 3'd0);
            phy_id_valid <= (sel == 3'd1);
            hdr_valid    <= (sel == 3'd2);
            sid_valid    <= (sel == 3'd3);
            sid_done     <= (sel == 3'd4);
            phy_id       <= v[5:0];
            {hdr_err, hdr_kind, hdr_node} <= v[10:0];
            sid_q        <= v;
            @(posedge ref_clk);
            {bus_reset, phy_id_valid, hdr_valid, sid_valid, sid_done} <= 5'h00;
            {hdr_err, hdr_kind, hdr_node, phy_id} <= ~{hdr_err, hdr_kind, hdr_node, phy_id};
            sid_q        <= ~sid_q;
        end
    endtask
endmodule
